// ===== core/caspc_pkg.sv
// Constants shared by the command/address parity checker.
package caspc_pkg;
  // Bus widths of the checked command/address word.
  localparam int ADDR_W = 16;
  localparam int BANK_W = 3;
  localparam int CS_W = 4;
  // Chip selects that count when four-select operation is off.
  localparam logic [3:0] CS_MASK_DUAL = 4'h3;
  localparam logic [3:0] CS_MASK_QUAD = 4'hF;
  // Cycles from the registered word to the error output.
  localparam int ERR_DELAY = 3;
  // Extra flag stages between the parity compare and the output register.
  localparam int MID_STAGES = ERR_DELAY - 2;
  // Cycles the error output stays low once asserted.
  localparam int HOLD_CYCLES = 2;
  localparam logic [0:0] HOLD_LOAD = 1'(HOLD_CYCLES - 1);
  // Released level of the active-low error output.
  localparam logic ERR_RELEASED = 1'b1;
endpackage

// ===== core/caspc_delay.sv
// Small flag delay line between the parity compare and the error output.
`timescale 1ns/1ns
module caspc_delay #(
  parameter int DEPTH = 1
) (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Flag in and delayed flag out.
  input wire logic flag_in,
  output logic flag_out
);
  logic [DEPTH-1:0] stage_reg;

  // Each stage is one flip-flop; reset clears every stage so no stale error survives.
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          stage_reg[i] <= 1'b0;
        end else if (clk_en) begin
          stage_reg[i] <= (i == 0) ? flag_in : stage_reg[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  assign flag_out = stage_reg[DEPTH-1];
endmodule // caspc_delay

// ===== core/caspc_checker.sv
// Command/address even-parity checker with a held, open-drain error output.
`timescale 1ns/1ns
module caspc_checker (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Sampled levels of the true and complement input clock pins.
  input wire logic ck_true_in,
  input wire logic ck_comp_in,
  // Mode strap.
  input wire logic four_select_operation,
  // Command/address inputs.
  input wire logic [caspc_pkg::CS_W-1:0] chip_select_in_n,
  input wire logic [caspc_pkg::ADDR_W-1:0] address_in,
  input wire logic [caspc_pkg::BANK_W-1:0] bank_address_in,
  input wire logic row_strobe_in_n,
  input wire logic column_strobe_in_n,
  input wire logic write_enable_in_n,
  input wire logic parity_bit_in,
  // Open-drain error pin: low level while the enable is high.
  output logic parity_error_n_o,
  output logic parity_error_n_oe,
  // Error level as it appears on the pin.
  output logic parity_error_n
);
  import caspc_pkg::*;

  // Pipeline at a glance, counted in enabled clock edges:
  //   edge t   : the word and its select state are registered.
  //   edge t+1 : the late parity bit meets the registered word; the first flag stage loads.
  //   edge t+2 : the middle stage in the delay line loads.
  //   edge t+3 : the output register pulls the pin low if it was released.
  //   edge t+4 : the hold counter steps down while the pin stays low.
  //   edge t+5 : the pin is released.
  // A deselected word flows through the same stages as a zero flag, so its
  // non-error result appears with the same latency as a checked one.
  // Results that reach the output while it is held are dropped on purpose;
  // queueing them would stretch a single fault into a long low pulse and hide
  // how many windows actually saw bad words.
  // Standby wins over the hold so a stopped clock never leaves the pin pulled
  // low, at the cost of losing an error that was still in flight.
  // The clock enable freezes every stage, including the hold counter, so a
  // frozen clock keeps the pin at whatever level it had.

  logic cs_active;
  logic word_odd;
  logic standby;
  logic cs_valid_reg;
  logic word_odd_reg;
  logic err1_reg;
  logic err1_next;
  logic err_mid;
  logic err_n_reg;
  logic [0:0] hold_cnt_reg;

  // Only the low chip selects of the active mode enable a check.
  assign cs_active = |(~chip_select_in_n & (four_select_operation ? CS_MASK_QUAD : CS_MASK_DUAL));
  // Sum only address, bank and strobes; chip selects are left out, and enables and termination are not ports here.
  assign word_odd = ^{address_in, bank_address_in, row_strobe_in_n, column_strobe_in_n, write_enable_in_n};
  // Both clock pins low means the controller stopped the clock for standby.
  assign standby = !ck_true_in && !ck_comp_in;

  // Register the word's parity and its select state on the crossing where it is presented.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_valid_reg <= 1'b0;
      word_odd_reg <= 1'b0;
    end else if (clk_en) begin
      cs_valid_reg <= cs_active;
      word_odd_reg <= word_odd;
    end
  end

  // Parity arrives one cycle late, so the compare uses the registered word.
  // A deselected word never flags, and its zero flag rides the same pipe.
  assign err1_next = cs_valid_reg && (word_odd_reg ^ parity_bit_in);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err1_reg <= 1'b0;
    end else if (clk_en) begin
      err1_reg <= err1_next;
    end
  end

  // Middle stages keep the total latency at three cycles.
  caspc_delay #(
    .DEPTH(MID_STAGES)
  ) u_delay (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .flag_in(err1_reg),
    .flag_out(err_mid)
  );

  // Error output register with its two-cycle hold.
  // While held low, incoming results are dropped rather than queued, so a burst of
  // bad words yields one pulse per free window, not one per word.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_n_reg <= ERR_RELEASED;
      hold_cnt_reg <= '0;
    end else if (clk_en) begin
      if (standby) begin
        err_n_reg <= ERR_RELEASED;
        hold_cnt_reg <= '0;
      end else if (err_n_reg) begin
        if (err_mid) begin
          err_n_reg <= 1'b0;
          hold_cnt_reg <= HOLD_LOAD;
        end
      end else if (hold_cnt_reg == '0) begin
        err_n_reg <= ERR_RELEASED;
      end else begin
        hold_cnt_reg <= hold_cnt_reg - 1'b1;
      end
    end
  end

  // The pin only ever pulls low; the board pull-up supplies the high.
  assign parity_error_n_o = 1'b0;
  assign parity_error_n_oe = !err_n_reg;
  assign parity_error_n = err_n_reg;

  // Checks below, except chk_reset_clear, are paused while the clock enable freezes the state.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n || !clk_en);

  // A word with a parity mismatch, then its parity one cycle later.
  sequence s_bad_word;
    cs_active ##1 (word_odd_reg != parity_bit_in);
  endsequence

  sequence s_good_word;
    cs_active ##1 (word_odd_reg == parity_bit_in);
  endsequence

  sequence s_free_output;
    err_n_reg && !standby;
  endsequence

  chk_error_latency: assert property (s_bad_word ##2 s_free_output |=> !err_n_reg)
    else $error("Parity error not flagged three cycles after the bad word.");

  chk_good_word_quiet: assert property (s_good_word ##2 s_free_output |=> err_n_reg)
    else $error("Error flagged for a word with even parity.");

  chk_deselect_quiet: assert property (!cs_active ##3 s_free_output |=> err_n_reg)
    else $error("Error flagged for a deselected cycle.");

  chk_hold_two_cycles: assert property ($fell(err_n_reg) && !standby |=> !err_n_reg)
    else $error("Error output released before two cycles.");

  chk_release_after_hold: assert property (!err_n_reg [*2] |=> err_n_reg)
    else $error("Error output held low longer than two cycles.");

  chk_standby_high: assert property (standby |=> err_n_reg)
    else $error("Error output not released while the clock is stopped low.");

  chk_dual_mode_mask: assert property (!four_select_operation && (&chip_select_in_n[1:0]) |=> !cs_valid_reg)
    else $error("Upper chip selects enabled a check outside four-select mode.");

  chk_pin_drive: assert property (parity_error_n_oe |-> !parity_error_n_o && !parity_error_n)
    else $error("Error pin driven without a low level.");

  // Counts enabled cycles the pin has been low, independent of the hold counter.
  logic [1:0] low_run_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_run_reg <= 2'h0;
    end else if (clk_en) begin
      if (err_n_reg) begin
        low_run_reg <= 2'h0;
      end else if (low_run_reg != 2'h3) begin
        low_run_reg <= low_run_reg + 2'h1;
      end
    end
  end

  // The last held cycle: the pin must come back even if a new result waits.
  sequence s_last_held;
    !err_n_reg && (hold_cnt_reg == '0) && !standby;
  endsequence

  // Any one low select enables a check in four-select operation.
  chk_quad_any_select: assert property (four_select_operation && !(&chip_select_in_n) |=> cs_valid_reg)
    else $error("A low chip select did not enable a check in four-select mode.");

  // Either of the lower selects enables a check in two-select operation.
  chk_dual_lower_select: assert property (!four_select_operation && !(&chip_select_in_n[1:0]) |=> cs_valid_reg)
    else $error("A low lower chip select did not enable a check.");

  // A mismatch against the late parity bit loads the first flag stage.
  chk_compare_stage: assert property (cs_valid_reg && (word_odd_reg != parity_bit_in) |=> err1_reg)
    else $error("Parity mismatch did not reach the first flag stage.");

  // A deselected word never loads a flag.
  chk_deselect_stage: assert property (!cs_valid_reg |=> !err1_reg)
    else $error("Deselected word loaded an error flag.");

  // Every fall of the pin loads the hold counter.
  chk_hold_load: assert property ($fell(err_n_reg) |-> hold_cnt_reg == HOLD_LOAD)
    else $error("Hold counter not loaded when the error output fell.");

  // The pin is never seen low for more than the hold length.
  chk_low_run_bound: assert property (!err_n_reg |-> low_run_reg < 2'(HOLD_CYCLES))
    else $error("Error output low for longer than the hold length.");

  // A result arriving in the last held cycle is dropped, not chained on.
  chk_held_drop: assert property (s_last_held |=> err_n_reg)
    else $error("Error output not released at the end of its hold.");

  // Reset clears the pipe and releases the pin, whatever the enable does.
  chk_reset_clear: assert property (disable iff (1'b0) !rst_n |=> err_n_reg && !err1_reg && !err_mid)
    else $error("Reset did not clear the pipeline and release the error output.");

endmodule // caspc_checker

// ===== tb/caspc_ctrl_model.sv
// Controller model that drives one command/address word and its parity a cycle later.
`timescale 1ns/1ns
module caspc_ctrl_model (
  // Clock, reset and request from the bench.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [3:0] cs_req,
  input wire logic [21:0] word_req,
  input wire logic flip,
  // Command/address bus.
  output logic [3:0] cs_n,
  output logic [21:0] word,
  output logic par
);
  logic par_next;
  // Idle cycles deselect and toggle the lines, so a stale word is never mistaken for a held one.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n <= 4'hF;
      word <= 22'h000000;
      par_next <= 1'b0;
    end else begin
      cs_n <= go ? cs_req : 4'hF;
      word <= go ? word_req : ~word;
      par_next <= go ? ((^word_req) ^ flip) : 1'b0;
    end
  end
  // Parity follows its word by one cycle; flip makes it wrong on purpose.
  always_ff @(posedge mclk) begin
    par <= par_next;
  end
endmodule // caspc_ctrl_model

// ===== tb/command_address_parity_checker_test.sv
// Self-checking bench for the command/address parity checker.
`timescale 1ns/1ns
module command_address_parity_checker_test;
  // Clock pin levels as sampled on a running clock; only standby stops them.
  logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, ck_t = 1'b1, ck_c = 1'b0, fs = 1'b0;
  logic go = 1'b0, flip = 1'b0, pin_o, pin_oe, pen, par;
  logic [3:0] cs_req = 4'hF, cs_n;
  logic [21:0] word_req = 22'h000000, word;
  int fail_count = 0, num_checks = 0;
  caspc_ctrl_model i_caspc_ctrl_model (.mclk(mclk), .rst_n(rst_n), .go(go), .cs_req(cs_req),
    .word_req(word_req), .flip(flip), .cs_n(cs_n), .word(word), .par(par));
  caspc_checker i_caspc_checker (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .ck_true_in(ck_t),
    .ck_comp_in(ck_c), .four_select_operation(fs), .chip_select_in_n(cs_n), .address_in(word[21:6]),
    .bank_address_in(word[5:3]), .row_strobe_in_n(word[2]), .column_strobe_in_n(word[1]),
    .write_enable_in_n(word[0]), .parity_bit_in(par), .parity_error_n_o(pin_o),
    .parity_error_n_oe(pin_oe), .parity_error_n(pen));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Sends n words back to back and follows the error pin to edge 8.
  task automatic run(input logic [3:0] cs, input logic [21:0] w, input logic f, input logic err, input int n);
    @(posedge mclk);
    go <= 1'b1;
    cs_req <= cs;
    word_req <= w;
    flip <= f;
    repeat (n) @(posedge mclk);
    go <= 1'b0;
    for (int i = n + 1; i <= 8; i++) begin
      @(posedge mclk);
      #1 chk(pen, !(err && (i == 5 || i == 6)));
      chk(pin_oe, (err && (i == 5 || i == 6)));
    end
  endtask
  task automatic t_table;
    run(4'hE, 22'h3FFFFE, 1'b0, 1'b0, 1);
    run(4'hE, 22'h3FFFFE, 1'b1, 1'b1, 1);
    run(4'hD, 22'h200001, 1'b0, 1'b0, 1);
    run(4'hD, 22'h200001, 1'b1, 1'b1, 1);
    chk(pin_o, 1'b0);
    $display("table done");
  endtask
  task automatic t_quad;
    run(4'hB, 22'h000001, 1'b1, 1'b0, 1);
    fs <= 1'b1;
    run(4'hB, 22'h000001, 1'b1, 1'b1, 1);
    run(4'h7, 22'h000001, 1'b1, 1'b1, 1);
    run(4'hF, 22'h000001, 1'b1, 1'b0, 1);
    fs <= 1'b0;
    $display("quad done");
  endtask
  task automatic t_burst;
    run(4'hE, 22'h000007, 1'b1, 1'b1, 3);
    $display("burst done");
  endtask
  // Standby, reset or freeze arrives one cycle before a bad word would flag.
  task automatic t_cut(input int m);
    @(posedge mclk);
    go <= 1'b1;
    cs_req <= 4'hE;
    word_req <= 22'h000001;
    flip <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (3) @(posedge mclk);
    // Standby is only entered while the pin is released.
    ck_t <= (m != 0);
    rst_n <= (m != 1);
    clk_en <= (m != 2);
    @(posedge mclk);
    ck_t <= 1'b1;
    rst_n <= 1'b1;
    clk_en <= 1'b1;
    #1 chk(pen, 1'b1);
    @(posedge mclk);
    #1 chk(pen, (m != 2));
    chk(pin_oe, (m == 2));
    @(posedge mclk);
    #1 chk(pen, (m != 2));
    @(posedge mclk);
    #1 chk(pen, 1'b1);
    $display("cut %0d done", m);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_table();
    t_quad();
    t_burst();
    for (int m = 0; m < 3; m++) begin
      t_cut(m);
    end
    report_and_stop();
  end
  // Watchdog against a hang.
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule // command_address_parity_checker_test
